// ---- hw/mmbd_decoder.v ----
`timescale 1ns/1ps
`include "mmbd_defs.vh"
// Summary of operation
// - Program memory is seen through two 32K windows, 18000-1FFFF and 08000-0FFFF, both reaching the bank the latch selects.
// - A write to FFF0 drives the bank latch low, a write to FFF1 or any access to FFFE drives it high.
// - The program part decode is strapped for a 32K or 64K part; the 128K strap, the default, decodes the same as 64K.
// - A switch places the 4K non-volatile block at 7000-7FFF or at 6000-6FFF.
// - Both switch positions reach the same physical 4K region of the non-volatile part.
// - The non-volatile part is a 32K device needing no battery circuitry.
// - Every device is selected by a complete decode of the address bus; only program memory appears twice, in its two windows.
// - Data lines are three-state and released whenever the module is not addressed.
// - Writes are inhibited while power is failing so stored contents are not corrupted.
// - Serial port four, power-fail, reset and restart-timer lines pass through to the option connector outputs.
module mmbd_decoder #(
    parameter ADDR_W = 17,
    parameter DATA_W = 8
) (
    input  wire              clock_in,
    input  wire              rstn_in,
    input  wire [ADDR_W-1:0] addr_in,
    input  wire [DATA_W-1:0] host_data_in,
    input  wire              host_rw_in,
    input  wire              host_strobe_in,
    input  wire [1:0]        part_size_in,
    input  wire              nvram_map_sel_in,
    input  wire              power_fail_n_in,
    input  wire              power_restore_reset_n_in,
    input  wire              restart_timer_out_in,
    input  wire              serial4_txd_in,
    input  wire [DATA_W-1:0] prog_data_in,
    input  wire [DATA_W-1:0] nvram_data_in,
    output reg  [DATA_W-1:0] host_data_out,
    output reg               host_data_oe_out,
    output reg               prog_sel_n_out,
    output reg  [16:0]       prog_addr_out,
    output reg               nvram_sel_n_out,
    output reg               nvram_we_n_out,
    output reg  [14:0]       nvram_addr_out,
    output reg  [DATA_W-1:0] nvram_data_out,
    output reg               module_present_out,
    output reg               option_power_fail_n_out,
    output reg               option_reset_n_out,
    output reg               option_restart_timer_out,
    output reg               option_serial4_txd_out,
    output reg               bank_out
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    // Bus and straps come from another domain, so two flops each
    localparam SW = ADDR_W + DATA_W + 9;
    wire [SW-1:0] raw_bus = {addr_in, host_data_in, host_rw_in, host_strobe_in, part_size_in,
                             nvram_map_sel_in, power_fail_n_in, power_restore_reset_n_in,
                             restart_timer_out_in, serial4_txd_in};
    reg  [SW-1:0] sync_a;
    reg  [SW-1:0] sync_b;
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_a <= {SW{1'b0}};
            sync_b <= {SW{1'b0}};
        end else begin
            sync_a <= raw_bus;
            sync_b <= sync_a;
        end
    end
    wire [ADDR_W-1:0] addr      = sync_b[SW-1 -: ADDR_W];
    wire [DATA_W-1:0] wdata     = sync_b[9 +: DATA_W];
    wire              rw        = sync_b[8];
    wire              strobe    = sync_b[7];
    wire [1:0]        part_size = sync_b[6:5];
    wire              map_sel   = sync_b[4];
    wire              pfail_n   = sync_b[3];
    wire              reset_n   = sync_b[2];
    wire              rtimer    = sync_b[1];
    wire              txd4      = sync_b[0];

    // ****************************************
    // Address decode
    // ****************************************
    // Full compare against every address bit, never a partial decode
    function is_exact;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] ref_addr;
        begin
            is_exact = (a == ref_addr);
        end
    endfunction

    function in_block;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] base;
        input integer      bits;
        reg   [ADDR_W-1:0] mask;
        begin
            mask     = ~(({{(ADDR_W-1){1'b0}}, 1'b1} << bits) - {{(ADDR_W-1){1'b0}}, 1'b1});
            in_block = ((a & mask) == base);
        end
    endfunction

    wire hit_lo_s  = is_exact(addr, `MMBD_BANK_LOW_STROBE);
    wire hit_hi_s  = is_exact(addr, `MMBD_BANK_HIGH_STROBE);
    wire hit_hi_a  = is_exact(addr, `MMBD_BANK_HIGH_ON_ACCESS);
    wire hit_ctl   = hit_lo_s || hit_hi_s || hit_hi_a;
    wire hit_high  = in_block(addr, `MMBD_PROG_HIGH_BASE, 15);
    wire hit_low   = in_block(addr, `MMBD_PROG_LOW_BASE, 15);
    wire hit_prog  = (hit_high || hit_low) && !hit_ctl;
    wire hit_nvram = map_sel ? in_block(addr, `MMBD_NVRAM_BASE_B, `MMBD_NVRAM_BLOCK_BITS)
                             : in_block(addr, `MMBD_NVRAM_BASE_A, `MMBD_NVRAM_BLOCK_BITS);

    // ****************************************
    // Bank latch
    // ****************************************
    reg strobe_d;
    reg bank;
    reg next_bank;
    wire strobe_rise = strobe && !strobe_d;
    always @* begin
        next_bank = bank;
        if (strobe_rise && !rw && hit_lo_s) begin
            next_bank = 1'b0;
        end else if (strobe_rise && !rw && hit_hi_s) begin
            next_bank = 1'b1;
        end else if (strobe_rise && hit_hi_a) begin
            next_bank = 1'b1;
        end
    end

    // Program address bit 15 depends on strapped part size, bit 16 stays 0
    reg [16:0] next_prog_addr;
    always @* begin
        next_prog_addr = {2'b00, addr[14:0]};
        if (part_size == `MMBD_PART_64K) begin
            next_prog_addr[15] = next_bank;
        end else if (part_size == `MMBD_PART_32K) begin
            next_prog_addr[15] = 1'b0;
        end else begin
            next_prog_addr[16] = 1'b0;
            next_prog_addr[15] = next_bank;
        end
    end

    // ****************************************
    // Shared qualifiers
    // ****************************************
    // Writes blocked while power-fail or reset low protect the part
    wire write_ok  = pfail_n && reset_n;
    wire selected  = hit_prog || hit_nvram;
    wire prog_acc  = strobe && hit_prog;
    wire nvram_acc = strobe && hit_nvram;
    wire nvram_wr  = nvram_acc && !rw && write_ok;
    wire host_read = strobe && rw && selected;

    // ****************************************
    // Bank latch registers
    // ****************************************
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            strobe_d <= 1'b0;
        end else begin
            strobe_d <= strobe;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bank <= `MMBD_BANK_RESET;
        end else begin
            bank <= next_bank;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bank_out <= `MMBD_BANK_RESET;
        end else begin
            bank_out <= next_bank;
        end
    end

    // ****************************************
    // Program memory outputs
    // ****************************************
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prog_sel_n_out <= 1'b1;
        end else begin
            prog_sel_n_out <= !prog_acc;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prog_addr_out <= 17'h00000;
        end else begin
            prog_addr_out <= next_prog_addr;
        end
    end

    // ****************************************
    // Non-volatile memory outputs
    // ****************************************
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvram_sel_n_out <= 1'b1;
        end else begin
            nvram_sel_n_out <= !nvram_acc;
        end
    end

    // One block of the 32K part whatever the map position
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvram_addr_out <= 15'h0000;
        end else begin
            nvram_addr_out <= `MMBD_NVRAM_BLOCK_BASE | {3'b000, addr[11:0]};
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvram_we_n_out <= 1'b1;
        end else begin
            nvram_we_n_out <= !nvram_wr;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvram_data_out <= {DATA_W{1'b0}};
        end else begin
            nvram_data_out <= wdata;
        end
    end

    // ****************************************
    // Host data bus
    // ****************************************
    // Drive only while addressed, otherwise the bus is left to others
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_data_oe_out <= 1'b0;
        end else begin
            host_data_oe_out <= host_read;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_data_out <= {DATA_W{1'b0}};
        end else begin
            host_data_out <= hit_nvram ? nvram_data_in : prog_data_in;
        end
    end

    // ****************************************
    // Presence flag and pass-through lines
    // ****************************************
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            module_present_out <= 1'b0;
        end else begin
            module_present_out <= 1'b1;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            option_power_fail_n_out <= 1'b0;
        end else begin
            option_power_fail_n_out <= pfail_n;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            option_reset_n_out <= 1'b0;
        end else begin
            option_reset_n_out <= reset_n;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            option_restart_timer_out <= 1'b1;
        end else begin
            option_restart_timer_out <= rtimer;
        end
    end

    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            option_serial4_txd_out <= 1'b1;
        end else begin
            option_serial4_txd_out <= txd4;
        end
    end
endmodule // mmbd_decoder

// ---- pkg/mmbd_defs.vh ----
`ifndef MMBD_DEFS_VH
`define MMBD_DEFS_VH
// ****************************************
// Address map
// ****************************************
`define MMBD_BANK_LOW_STROBE       17'h0FFF0
`define MMBD_BANK_HIGH_STROBE      17'h0FFF1
`define MMBD_BANK_HIGH_ON_ACCESS   17'h0FFFE
`define MMBD_PROG_HIGH_BASE        17'h18000
`define MMBD_PROG_LOW_BASE         17'h08000
`define MMBD_NVRAM_BASE_A          17'h07000
`define MMBD_NVRAM_BASE_B          17'h06000
// ****************************************
// Field positions and sizes
// ****************************************
`define MMBD_PROG_BANK_BIT         15
`define MMBD_NVRAM_BLOCK_BITS      12
`define MMBD_NVRAM_BLOCK_BASE      15'h7000
// ****************************************
// Reset values and part sizes
// ****************************************
`define MMBD_BANK_RESET            1'b1
`define MMBD_PART_32K              2'h0
`define MMBD_PART_64K              2'h1
`define MMBD_PART_128K             2'h2
`define MMBD_PART_DEFAULT          2'h2
// ****************************************
// Timing
// ****************************************
`define MMBD_SYNC_STAGES           2
`endif

// ---- verif/mmbd_decoder_checker.sv ----
`timescale 1ns/1ps
module mmbd_decoder_checker (
    input wire        clock_in,
    input wire        rstn_in,
    input wire [16:0] addr_in,
    input wire        host_rw_in,
    input wire        host_strobe_in,
    input wire        nvram_map_sel_in,
    input wire        power_fail_n_in,
    input wire        host_data_oe_out,
    input wire        prog_sel_n_out,
    input wire        nvram_sel_n_out,
    input wire        nvram_we_n_out,
    input wire [14:0] nvram_addr_out,
    input wire        bank_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);
    wire wr = host_strobe_in && !host_rw_in;
    wire nv = addr_in[16:12] == (nvram_map_sel_in ? 5'h06 : 5'h07);
    AST_BANK_LOW: assert property ((wr && addr_in == 17'h0FFF0)[*4] |-> !bank_out) else $error("bank not low");
    AST_BANK_HIGH: assert property ((wr && addr_in == 17'h0FFF1)[*4] |-> bank_out) else $error("bank not high");
    AST_BANK_ANY: assert property ((host_strobe_in && addr_in == 17'h0FFFE)[*4] |-> bank_out) else $error("bank");
    AST_BANK_HOLD: assert property (!host_strobe_in[*5] |-> $stable(bank_out)) else $error("bank moved");
    AST_PROG_HIGH: assert property ((host_strobe_in && host_rw_in && addr_in[16:15] == 2'h3)[*4]
        |-> !prog_sel_n_out && host_data_oe_out) else $error("high bank read");
    AST_NV_SEL: assert property ((host_strobe_in && nv)[*4]
        |-> !nvram_sel_n_out && nvram_addr_out == {3'h7, addr_in[11:0]}) else $error("nv block");
    AST_FULL_DECODE: assert property ((host_strobe_in && addr_in[16:15] == 2'h0 && !nv)[*4]
        |-> nvram_sel_n_out && prog_sel_n_out && !host_data_oe_out) else $error("alias");
    AST_PF_WE: assert property (!power_fail_n_in[*4] |-> nvram_we_n_out) else $error("write in outage");
    cover property (wr && addr_in == 17'h0FFF0);
    cover property (host_strobe_in && nv);
    cover property (wr && !power_fail_n_in);
endmodule // mmbd_decoder_checker
bind mmbd_decoder mmbd_decoder_checker mmbd_decoder_checker_inst (.clock_in, .rstn_in, .addr_in, .host_rw_in,
    .host_strobe_in, .nvram_map_sel_in, .power_fail_n_in, .host_data_oe_out, .prog_sel_n_out, .nvram_sel_n_out,
    .nvram_we_n_out, .nvram_addr_out, .bank_out);

// ---- verif/mmbd_mem_model.sv ----
`timescale 1ns/1ps
module mmbd_mem_model (
    input  wire        clock_in,
    input  wire        prog_sel_n_in,
    input  wire [16:0] prog_addr_in,
    input  wire        nvram_sel_n_in,
    input  wire        nvram_we_n_in,
    input  wire [14:0] nvram_addr_in,
    input  wire [7:0]  nvram_data_in,
    output reg  [7:0]  prog_data_out = 8'hA5,
    output reg  [7:0]  nvram_data_out = 8'h3C
);
    reg [7:0] cells [0:32767]; // Battery-free 32K part
    // Released lines toggle so stale data never passes
    always @(posedge clock_in) begin
        prog_data_out <= prog_sel_n_in ? ~prog_data_out : prog_addr_in[15:8] ^ prog_addr_in[7:0];
        if (!nvram_sel_n_in && !nvram_we_n_in) cells[nvram_addr_in] <= nvram_data_in;
        nvram_data_out <= nvram_sel_n_in ? ~nvram_data_out : cells[nvram_addr_in];
    end
endmodule // mmbd_mem_model

// ---- verif/memory_module_bank_decoder_test.sv ----
`timescale 1ns/1ps
module memory_module_bank_decoder_test;
    reg clock_in = 0, rstn_in = 0, host_rw_in = 1, host_strobe_in = 0, nvram_map_sel_in = 0, power_fail_n_in = 1;
    reg power_restore_reset_n_in = 1, restart_timer_out_in = 1, serial4_txd_in = 1;
    reg  [16:0] addr_in = 0;
    reg  [7:0]  host_data_in = 0;
    reg  [1:0]  part_size_in = 2;
    wire [7:0]  prog_data_in, nvram_data_in, host_data_out, nvram_data_out;
    wire [16:0] prog_addr_out;
    wire [14:0] nvram_addr_out;
    wire host_data_oe_out, prog_sel_n_out, nvram_sel_n_out, nvram_we_n_out, module_present_out, bank_out;
    wire option_power_fail_n_out, option_reset_n_out, option_restart_timer_out, option_serial4_txd_out;
    integer n_errors = 0, cmp_count = 0, cyc = 0, p, b;
    reg [15:0] e;
    // Host board jumpers route all program memory and the 4K block here
    mmbd_decoder mmbd_decoder_inst (.clock_in, .rstn_in, .addr_in, .host_data_in, .host_rw_in, .host_strobe_in,
        .part_size_in, .nvram_map_sel_in, .power_fail_n_in, .power_restore_reset_n_in, .restart_timer_out_in,
        .serial4_txd_in, .prog_data_in, .nvram_data_in, .host_data_out, .host_data_oe_out, .prog_sel_n_out,
        .prog_addr_out, .nvram_sel_n_out, .nvram_we_n_out, .nvram_addr_out, .nvram_data_out, .module_present_out,
        .option_power_fail_n_out, .option_reset_n_out, .option_restart_timer_out, .option_serial4_txd_out, .bank_out);
    mmbd_mem_model mmbd_mem_model_inst (.clock_in(clock_in), .prog_sel_n_in(prog_sel_n_out),
        .prog_addr_in(prog_addr_out), .nvram_sel_n_in(nvram_sel_n_out), .nvram_we_n_in(nvram_we_n_out),
        .nvram_addr_in(nvram_addr_out), .nvram_data_in(nvram_data_out), .prog_data_out(prog_data_in),
        .nvram_data_out(nvram_data_in));
    always #5 clock_in = ~clock_in;
    task w(input integer n);
        begin
            repeat (n) @(posedge clock_in);
            #1;
        end
    endtask
    task chk(input [16:0] got, input [16:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Strobe drops first, address settles, then strobe stands long enough for read data
    task acc(input [16:0] a, input r, input [7:0] d);
        begin
            host_strobe_in = 0;
            w(4);
            addr_in = a;
            host_rw_in = r;
            host_data_in = d;
            w(3);
            host_strobe_in = 1;
            w(6);
        end
    endtask
    task t_bank;
        begin
            chk(bank_out, 1);
            acc(17'h0FFF0, 0, 0);
            chk(bank_out, 0);
            acc(17'h0FFF1, 1, 0);
            chk(bank_out, 0);
            acc(17'h0FFF1, 0, 0);
            chk(bank_out, 1);
            acc(17'h0FFF0, 0, 0);
            acc(17'h0FFFE, 1, 0);
            chk(bank_out, 1);
            $display("t_bank done");
        end
    endtask
    task t_prog;
        begin
            for (p = 0; p < 3; p = p + 1) begin
                for (b = 0; b < 2; b = b + 1) begin
                    acc(b ? 17'h0FFF1 : 17'h0FFF0, 0, 0);
                    host_strobe_in = 0;
                    part_size_in = p;
                    acc(17'h0A5C3, 1, 0);
                    e = {(p != 0) && (b != 0), 15'h25C3};
                    chk(prog_addr_out[15:0], e);
                    chk({prog_sel_n_out, host_data_oe_out, host_data_out}, {2'b01, e[15:8] ^ e[7:0]});
                end
            end
            acc(17'h18000, 1, 0);
            chk(prog_sel_n_out, 0);
            $display("t_prog done");
        end
    endtask
    task t_nv;
        begin
            acc(17'h07ABC, 0, 8'h5A);
            chk(nvram_addr_out, 15'h7ABC);
            host_strobe_in = 0;
            nvram_map_sel_in = 1;
            acc(17'h06ABC, 1, 0);
            chk(host_data_out, 8'h5A);
            acc(17'h07ABC, 1, 0);
            chk({nvram_sel_n_out, host_data_oe_out}, 2'b10);
            acc(17'h16ABC, 1, 0);
            chk({nvram_sel_n_out, prog_sel_n_out}, 2'b11);
            host_strobe_in = 0;
            power_fail_n_in = 0;
            acc(17'h06ABC, 0, 8'h33);
            chk({nvram_we_n_out, option_power_fail_n_out}, 2'b10);
            power_restore_reset_n_in = 0;
            w(4);
            chk(option_reset_n_out, 0);
            host_strobe_in = 0;
            power_fail_n_in = 1;
            power_restore_reset_n_in = 1;
            acc(17'h06ABC, 1, 0);
            chk(host_data_out, 8'h5A);
            $display("t_nv done");
        end
    endtask
    task t_pass;
        begin
            {restart_timer_out_in, serial4_txd_in, power_restore_reset_n_in} = 3'h2;
            w(4);
            chk({option_restart_timer_out, option_serial4_txd_out, option_reset_n_out, module_present_out}, 4'h5);
            $display("t_pass done");
        end
    endtask
    task final_report;
        begin
            $display("errors %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge clock_in) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    initial begin
        w(12);
        rstn_in = 1;
        w(2);
        t_bank;
        t_prog;
        t_nv;
        t_pass;
        final_report;
    end
endmodule // memory_module_bank_decoder_test
